// ---- common/hsc_pkg.sv ----
// constants, carriers and decode functions for the serdes control bank
package hsc_pkg;

  localparam logic [4:0] HSC_DEVAD = 5'h1e;
  localparam logic [15:0] HSC_PLL_ADDR = 16'h0002;
  localparam logic [15:0] HSC_TRX_ADDR = 16'h0003;
  localparam logic [15:0] HSC_PLL_RESET = 16'h811d;
  localparam logic [15:0] HSC_TRX_RESET = 16'h8848;

  // pll control field positions
  localparam int HSC_PLL_VENDOR_HI = 15;
  localparam int HSC_PLL_VENDOR_LO = 10;
  localparam int HSC_LOOP_BW_HI = 9;
  localparam int HSC_LOOP_BW_LO = 8;
  localparam int HSC_PLL_ON_BIT = 4;
  localparam int HSC_MULT_HI = 3;
  localparam int HSC_MULT_LO = 0;

  // transmit/receive control field positions
  localparam int HSC_SWING_HI = 15;
  localparam int HSC_SWING_LO = 12;
  localparam int HSC_TX_ON_BIT = 11;
  localparam int HSC_EQ_FREEZE_BIT = 10;
  localparam int HSC_TX_RATE_HI = 9;
  localparam int HSC_TX_RATE_LO = 8;
  localparam int HSC_TRX_VENDOR_HI = 7;
  localparam int HSC_TRX_VENDOR_LO = 4;
  localparam int HSC_RX_ON_BIT = 3;
  localparam int HSC_RX_RATE_HI = 2;
  localparam int HSC_RX_RATE_LO = 0;

  localparam logic [1:0] HSC_LOOP_BW_RSVD = 2'h0;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] devad;
    logic [15:0] regad;
    logic [15:0] wdata;
  } hsc_mgmt_req_t;

  typedef struct packed {
    logic pll_on;
    logic transmitter_on;
    logic receiver_on;
    logic eq_freeze;
    logic [1:0] loop_bw;
    logic loop_bw_rsvd;
    logic [3:0] mult;
    logic [6:0] mult_x4;
    logic mult_rsvd;
    logic [3:0] swing;
    logic [1:0] tx_rate;
    logic [2:0] rx_rate;
    logic [1:0] rx_div_log2;
    logic rx_rate_rsvd;
    logic [5:0] pll_vendor;
    logic [3:0] trx_vendor;
  } hsc_ctl_t;

  // multiplier in quarter steps, zero for reserved codes
  function automatic logic [6:0] hsc_mult_x4(input logic [3:0] code);
    unique case (code)
      4'h2: hsc_mult_x4 = 7'h10;
      4'h3: hsc_mult_x4 = 7'h14;
      4'h4: hsc_mult_x4 = 7'h18;
      4'h5: hsc_mult_x4 = 7'h20;
      4'h6: hsc_mult_x4 = 7'h21;
      4'h7: hsc_mult_x4 = 7'h28;
      4'h8: hsc_mult_x4 = 7'h30;
      4'h9: hsc_mult_x4 = 7'h32;
      4'ha: hsc_mult_x4 = 7'h3c;
      4'hb: hsc_mult_x4 = 7'h40;
      4'hc: hsc_mult_x4 = 7'h42;
      4'hd: hsc_mult_x4 = 7'h50;
      4'he: hsc_mult_x4 = 7'h64;
      default: hsc_mult_x4 = 7'h00;
    endcase
  endfunction : hsc_mult_x4

  // receive rate to {reserved, log2 divider}
  function automatic logic [2:0] hsc_rx_div(input logic [2:0] code);
    unique case (code)
      3'h0: hsc_rx_div = 3'h0;
      3'h5: hsc_rx_div = 3'h1;
      3'h6: hsc_rx_div = 3'h2;
      3'h7: hsc_rx_div = 3'h3;
      default: hsc_rx_div = 3'h4;
    endcase
  endfunction : hsc_rx_div

endpackage : hsc_pkg

// ---- design/hsc_ctl_reg.sv ----
// one 16-bit read/write control register with a reset value
module hsc_ctl_reg
  import hsc_pkg::*;
#(
  parameter logic [15:0] RESET_VALUE = 16'h0000
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [15:0] wdata,
  output logic [15:0] q
);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q <= RESET_VALUE;
    else if (wr_en)
      q <= wdata;
  end

endmodule : hsc_ctl_reg

// ---- design/hsc_serdes_ctl.sv ----
// serdes pll and transmit/receive control register bank
module hsc_serdes_ctl
  import hsc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire hsc_mgmt_req_t MGMT_REQ,
  output logic [15:0] MGMT_RDATA,
  output logic MGMT_RVALID,
  output logic MGMT_RHIT,
  input wire logic CHANNEL_DATAPATH_SLEEP_PIN_N,
  input wire logic DATAPATH_SLEEP,
  input wire logic REFCLK_FREQUENCY_SELECT_HI,
  input wire logic RATE_OVERRIDE,
  input wire logic [3:0] AUTO_MULT,
  input wire logic [1:0] AUTO_TX_RATE,
  input wire logic [2:0] AUTO_RX_RATE,
  output hsc_ctl_t SERDES_CTL
);

  logic [15:0] pll_q;
  logic [15:0] trx_q;
  hsc_ctl_t next_ctl;
  logic [15:0] next_rdata;
  logic [2:0] rx_dec;

  // address decode
  wire dev_hit = MGMT_REQ.devad == HSC_DEVAD;
  wire pll_sel = dev_hit && MGMT_REQ.regad == HSC_PLL_ADDR;
  wire trx_sel = dev_hit && MGMT_REQ.regad == HSC_TRX_ADDR;
  wire pll_wr = MGMT_REQ.wr && pll_sel;
  wire trx_wr = MGMT_REQ.wr && trx_sel;
  wire power_off = !CHANNEL_DATAPATH_SLEEP_PIN_N || DATAPATH_SLEEP;
  wire use_manual = REFCLK_FREQUENCY_SELECT_HI || RATE_OVERRIDE;

  hsc_ctl_reg #(.RESET_VALUE(HSC_PLL_RESET)) u_pll_reg
  (
    .clk(MCLK),
    .rst_n(RST_N),
    .wr_en(pll_wr),
    .wdata(MGMT_REQ.wdata),
    .q(pll_q)
  );

  hsc_ctl_reg #(.RESET_VALUE(HSC_TRX_RESET)) u_trx_reg
  (
    .clk(MCLK),
    .rst_n(RST_N),
    .wr_en(trx_wr),
    .wdata(MGMT_REQ.wdata),
    .q(trx_q)
  );

  // readback of stored values, unmapped reads return zero
  assign next_rdata = pll_sel ? pll_q : (trx_sel ? trx_q : 16'h0000);

  // effective controls
  assign next_ctl.pll_on = pll_q[HSC_PLL_ON_BIT] && !power_off;
  assign next_ctl.transmitter_on = trx_q[HSC_TX_ON_BIT] && !power_off;
  assign next_ctl.receiver_on = trx_q[HSC_RX_ON_BIT] && !power_off;
  assign next_ctl.eq_freeze = trx_q[HSC_EQ_FREEZE_BIT];
  assign next_ctl.loop_bw = pll_q[HSC_LOOP_BW_HI:HSC_LOOP_BW_LO];
  assign next_ctl.loop_bw_rsvd = next_ctl.loop_bw == HSC_LOOP_BW_RSVD;
  assign next_ctl.mult = use_manual ? pll_q[HSC_MULT_HI:HSC_MULT_LO] : AUTO_MULT;
  assign next_ctl.mult_x4 = hsc_mult_x4(next_ctl.mult);
  assign next_ctl.mult_rsvd = next_ctl.mult_x4 == 7'h00;
  assign next_ctl.swing = trx_q[HSC_SWING_HI:HSC_SWING_LO];
  assign next_ctl.tx_rate = use_manual ? trx_q[HSC_TX_RATE_HI:HSC_TX_RATE_LO]
                                       : AUTO_TX_RATE;
  assign next_ctl.rx_rate = use_manual ? trx_q[HSC_RX_RATE_HI:HSC_RX_RATE_LO]
                                       : AUTO_RX_RATE;
  assign rx_dec = hsc_rx_div(next_ctl.rx_rate);
  assign next_ctl.rx_div_log2 = rx_dec[1:0];
  assign next_ctl.rx_rate_rsvd = rx_dec[2];
  assign next_ctl.pll_vendor = pll_q[HSC_PLL_VENDOR_HI:HSC_PLL_VENDOR_LO];
  assign next_ctl.trx_vendor = trx_q[HSC_TRX_VENDOR_HI:HSC_TRX_VENDOR_LO];

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      SERDES_CTL <= '0;
      MGMT_RDATA <= 16'h0000;
      MGMT_RVALID <= 1'b0;
      MGMT_RHIT <= 1'b0;
    end
    else
    begin
      SERDES_CTL <= next_ctl;
      MGMT_RDATA <= MGMT_REQ.rd ? next_rdata : 16'h0000;
      MGMT_RVALID <= MGMT_REQ.rd;
      MGMT_RHIT <= MGMT_REQ.rd && (pll_sel || trx_sel);
    end
  end

  // checks
  property p_pll_reset;
    @(posedge MCLK) !RST_N |=> pll_q == HSC_PLL_RESET;
  endproperty
  a_pll_reset: assert property (p_pll_reset) else $error("pll reset value wrong");

  property p_trx_reset;
    @(posedge MCLK) !RST_N |=> trx_q == HSC_TRX_RESET && trx_q[HSC_SWING_HI:HSC_SWING_LO] == 4'h8;
  endproperty
  a_trx_reset: assert property (p_trx_reset) else $error("trx reset value wrong");

  property p_pll_write;
    @(posedge MCLK) disable iff (!RST_N) pll_wr |=> pll_q == $past(MGMT_REQ.wdata);
  endproperty
  a_pll_write: assert property (p_pll_write) else $error("pll write lost");

  property p_pll_off;
    @(posedge MCLK) disable iff (!RST_N) power_off |=> !SERDES_CTL.pll_on;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("pll not forced off");

  property p_tx_off;
    @(posedge MCLK) disable iff (!RST_N)
      (!CHANNEL_DATAPATH_SLEEP_PIN_N || DATAPATH_SLEEP) |=> !SERDES_CTL.transmitter_on;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("transmitter not forced off");

  property p_rx_on;
    @(posedge MCLK) disable iff (!RST_N)
      !power_off && trx_q[HSC_RX_ON_BIT] |=> SERDES_CTL.receiver_on;
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("receiver enable wrong");

  property p_mult_auto;
    @(posedge MCLK) disable iff (!RST_N) !use_manual |=> SERDES_CTL.mult == $past(AUTO_MULT);
  endproperty
  a_mult_auto: assert property (p_mult_auto) else $error("auto multiplier not used");

  property p_rate_manual;
    @(posedge MCLK) disable iff (!RST_N)
      use_manual |=> SERDES_CTL.tx_rate == $past(trx_q[HSC_TX_RATE_HI:HSC_TX_RATE_LO]);
  endproperty
  a_rate_manual: assert property (p_rate_manual) else $error("manual tx rate not used");

  property p_readback;
    @(posedge MCLK) disable iff (!RST_N)
      MGMT_REQ.rd && trx_sel |=> MGMT_RVALID && MGMT_RDATA == $past(trx_q);
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_eq_freeze;
    @(posedge MCLK) disable iff (!RST_N)
      SERDES_CTL.eq_freeze == $past(trx_q[HSC_EQ_FREEZE_BIT]);
  endproperty
  a_eq_freeze: assert property (p_eq_freeze) else $error("equalizer freeze wrong");

  property p_mult_decode;
    @(posedge MCLK) disable iff (!RST_N)
      SERDES_CTL.mult == 4'hd |-> SERDES_CTL.mult_x4 == 7'h50 && !SERDES_CTL.mult_rsvd;
  endproperty
  a_mult_decode: assert property (p_mult_decode) else $error("multiplier decode wrong");

  property p_rx_decode;
    @(posedge MCLK) disable iff (!RST_N)
      SERDES_CTL.rx_rate == 3'h5 |-> SERDES_CTL.rx_div_log2 == 2'h1 && !SERDES_CTL.rx_rate_rsvd;
  endproperty
  a_rx_decode: assert property (p_rx_decode) else $error("rx rate decode wrong");

  property p_bw_rsvd;
    @(posedge MCLK) disable iff (!RST_N)
      $past(RST_N) |-> SERDES_CTL.loop_bw == $past(pll_q[HSC_LOOP_BW_HI:HSC_LOOP_BW_LO]) &&
        SERDES_CTL.loop_bw_rsvd == (SERDES_CTL.loop_bw == 2'h0);
  endproperty
  a_bw_rsvd: assert property (p_bw_rsvd) else $error("loop bandwidth flag wrong");

  property p_swing_track;
    @(posedge MCLK) disable iff (!RST_N)
      $past(RST_N) |-> SERDES_CTL.swing == $past(trx_q[HSC_SWING_HI:HSC_SWING_LO]);
  endproperty
  a_swing_track: assert property (p_swing_track) else $error("swing not applied");

  property p_vendor_keep;
    @(posedge MCLK) disable iff (!RST_N)
      $past(RST_N) |->
        SERDES_CTL.pll_vendor == $past(pll_q[HSC_PLL_VENDOR_HI:HSC_PLL_VENDOR_LO]) &&
        SERDES_CTL.trx_vendor == $past(trx_q[HSC_TRX_VENDOR_HI:HSC_TRX_VENDOR_LO]);
  endproperty
  a_vendor_keep: assert property (p_vendor_keep) else $error("vendor field not kept");

  property p_foreign_write;
    @(posedge MCLK) disable iff (!RST_N)
      MGMT_REQ.wr && !pll_sel && !trx_sel |=> pll_q == $past(pll_q) && trx_q == $past(trx_q);
  endproperty
  a_foreign_write: assert property (p_foreign_write) else $error("stray write landed");

  property p_sleep_write;
    @(posedge MCLK) disable iff (!RST_N)
      power_off && trx_wr |=> trx_q == $past(MGMT_REQ.wdata);
  endproperty
  a_sleep_write: assert property (p_sleep_write) else $error("datapath_sleep write lost");

  property p_cov_sleep_write;
    @(posedge MCLK) disable iff (!RST_N) DATAPATH_SLEEP && pll_wr;
  endproperty
  c_sleep_write: cover property (p_cov_sleep_write);

  property p_cov_manual_mult;
    @(posedge MCLK) disable iff (!RST_N) use_manual && pll_wr ##2 SERDES_CTL.mult_rsvd;
  endproperty
  c_manual_mult: cover property (p_cov_manual_mult);

  property p_cov_read_after_write;
    @(posedge MCLK) disable iff (!RST_N) trx_wr ##2 (MGMT_REQ.rd && trx_sel);
  endproperty
  c_read_after_write: cover property (p_cov_read_after_write);

  property p_cov_pin_write;
    @(posedge MCLK) disable iff (!RST_N) !CHANNEL_DATAPATH_SLEEP_PIN_N && trx_wr;
  endproperty
  c_pin_write: cover property (p_cov_pin_write);

  property p_cov_rd_wr_same;
    @(posedge MCLK) disable iff (!RST_N) MGMT_REQ.rd && trx_wr;
  endproperty
  c_rd_wr_same: cover property (p_cov_rd_wr_same);

endmodule : hsc_serdes_ctl

// ---- verif/tb.sv ----
// self-checking bench for the serdes control register bank
module tb
  import hsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  hsc_mgmt_req_t req = '0;
  logic [15:0] rdata;
  logic rvalid;
  logic rhit;
  logic pd_n = 1'b1;
  logic sleep = 1'b0;
  logic fsel = 1'b0;
  logic ovr = 1'b0;
  logic [3:0] amult = 4'h7;
  logic [1:0] atx = 2'h3;
  logic [2:0] arx = 3'h6;
  hsc_ctl_t ctl;
  int miscompares = 0;
  int checks = 0;
  // multiplier factor times four, zero where reserved
  logic [6:0] x4 [16] = '{7'h00, 7'h00, 7'h10, 7'h14, 7'h18, 7'h20, 7'h21, 7'h28,
                          7'h30, 7'h32, 7'h3c, 7'h40, 7'h42, 7'h50, 7'h64, 7'h00};
  always #2 mclk = ~mclk;
  hsc_serdes_ctl u_hsc_serdes_ctl (
    .MCLK(mclk),
    .RST_N(rst_n),
    .MGMT_REQ(req),
    .MGMT_RDATA(rdata),
    .MGMT_RVALID(rvalid),
    .MGMT_RHIT(rhit),
    .CHANNEL_DATAPATH_SLEEP_PIN_N(pd_n),
    .DATAPATH_SLEEP(sleep),
    .REFCLK_FREQUENCY_SELECT_HI(fsel),
    .RATE_OVERRIDE(ovr),
    .AUTO_MULT(amult),
    .AUTO_TX_RATE(atx),
    .AUTO_RX_RATE(arx),
    .SERDES_CTL(ctl)
  );
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic r, input logic w, input logic [4:0] dv,
                     input logic [15:0] ra, input logic [15:0] wd);
    @(posedge mclk);
    #1 req = '{rd: r, wr: w, devad: dv, regad: ra, wdata: wd};
    @(posedge mclk);
    #1 req = '0;
  endtask : acc
  task automatic wr(input logic [15:0] ra, input logic [15:0] wd);
    acc(1'b0, 1'b1, 5'h1e, ra, wd);
  endtask : wr
  task automatic rd(input logic [4:0] dv, input logic [15:0] ra, input logic [15:0] exp,
                    input logic hit);
    acc(1'b1, 1'b0, dv, ra, 16'h0000);
    chk(rdata, exp);
    chk({rvalid, rhit}, {1'b1, hit});
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle
  task automatic tally_and_finish;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    logic [3:0] c;
    logic [15:0] v;
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    settle();
    chk({ctl.pll_on, ctl.transmitter_on}, 2'h3);
    chk({ctl.receiver_on, ctl.eq_freeze}, 2'h2);
    chk({ctl.loop_bw, ctl.swing}, {2'h1, 4'h8});
    chk({ctl.pll_vendor, ctl.trx_vendor}, {6'h20, 4'h4});
    rd(5'h1e, 16'h0002, 16'h811d, 1'b1);
    rd(5'h1e, 16'h0003, 16'h8848, 1'b1);
    $display("test reset done");
    rd(5'h1e, 16'h0004, 16'h0000, 1'b0);
    rd(5'h1f, 16'h0002, 16'h0000, 1'b0);
    acc(1'b0, 1'b1, 5'h1f, 16'h0002, 16'h0000);
    wr(16'h0004, 16'h0000);
    rd(5'h1e, 16'h0002, 16'h811d, 1'b1);
    rd(5'h1e, 16'h0003, 16'h8848, 1'b1);
    $display("test unmapped done");
    fsel = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      c = i[3:0];
      v = {6'h2a, c[1:0], 3'h0, c[2], c};
      wr(16'h0002, v);
      settle();
      chk({ctl.mult, ctl.pll_on}, {c, c[2]});
      chk({ctl.loop_bw, ctl.loop_bw_rsvd}, {c[1:0], c[1:0] == 2'h0});
      chk({ctl.mult_x4, ctl.mult_rsvd}, {x4[i], x4[i] == 7'h00});
      chk(ctl.pll_vendor, 6'h2a);
      rd(5'h1e, 16'h0002, v, 1'b1);
    end
    fsel = 1'b0;
    settle();
    chk(ctl.mult, amult);
    rd(5'h1e, 16'h0002, v, 1'b1);
    amult = 4'hb;
    settle();
    chk(ctl.mult, 4'hb);
    ovr = 1'b1;
    settle();
    chk(ctl.mult, c);
    $display("test pll done");
    for (int i = 0; i < 16; i++)
    begin
      c = i[3:0];
      v = {c, c[0], c[1], c[1:0], 4'h9, c[2], c[2:0]};
      wr(16'h0003, v);
      settle();
      chk({ctl.swing, ctl.transmitter_on, ctl.eq_freeze}, {c, c[0], c[1]});
      chk({ctl.tx_rate, ctl.receiver_on, ctl.rx_rate}, {c[1:0], c[2], c[2:0]});
      chk(ctl.trx_vendor, 4'h9);
      chk(ctl.rx_rate_rsvd, c[2:0] inside {3'h1, 3'h2, 3'h3, 3'h4});
      if (c[2:0] == 3'h0 || c[2:0] > 3'h4)
        chk(ctl.rx_div_log2, c[2:0] == 3'h0 ? 2'h0 : 2'(c[2:0] - 3'h4));
      rd(5'h1e, 16'h0003, v, 1'b1);
    end
    ovr = 1'b0;
    settle();
    chk({ctl.tx_rate, ctl.rx_rate}, {atx, arx});
    atx = 2'h1;
    arx = 3'h5;
    settle();
    chk({ctl.tx_rate, ctl.rx_rate, ctl.rx_div_log2}, {2'h1, 3'h5, 2'h1});
    $display("test rates done");
    wr(16'h0002, 16'h811d);
    wr(16'h0003, 16'h8848);
    pd_n = 1'b0;
    settle();
    chk({ctl.pll_on, ctl.transmitter_on, ctl.receiver_on}, 3'h0);
    wr(16'h0003, 16'h8840);
    rd(5'h1e, 16'h0003, 16'h8840, 1'b1);
    pd_n = 1'b1;
    settle();
    chk({ctl.pll_on, ctl.transmitter_on, ctl.receiver_on}, 3'h6);
    sleep = 1'b1;
    settle();
    chk({ctl.pll_on, ctl.transmitter_on, ctl.receiver_on}, 3'h0);
    chk(ctl.swing, 4'h8);
    wr(16'h0002, 16'h810d);
    rd(5'h1e, 16'h0002, 16'h810d, 1'b1);
    sleep = 1'b0;
    settle();
    chk({ctl.pll_on, ctl.transmitter_on}, 2'h1);
    acc(1'b1, 1'b1, 5'h1e, 16'h0003, 16'h1234);
    chk(rdata, 16'h8840);
    rd(5'h1e, 16'h0003, 16'h1234, 1'b1);
    $display("test datapath_sleep done");
    tally_and_finish();
  end
endmodule : tb
